/* design/physt_defines.svh */
/*
 constants for the phy status and auto-negotiation register set:
 register indexes, field positions, reset values, fixed codes.
 assumes inclusion by every design file of the block that uses its macros, bench included.
*/
// Summary of operation
// R1: status bits 15..11 fixed 0,1,1,1,1
// R2: status bit 5 shows negotiation finished
// R3: status bit 4 latches remote fault high
// R4: status bit 2 link, latching low
// R5: status bit 1 latches jabber high
// R6: status bit 3 always reads one
// R7: status bit 0 one, bits 10..6 zero
// R8: identifier high returns oui bits 3..18
// R9: identifier low 15..10 oui bits 19..24
// R10: identifier low holds model and revision
// R11: advertise bit 13 writable, resets zero
// R12: pause field 11:10 writable, resets 00
// R13: both pause advertised settles to one
// R14: ability bits 8..5 writable, 8, 6 and 5 strap resets, 7 resets one
// R15: selector 4:0 writable, resets 00001
// R16: no next page, partner bit 15 zero
// R17: partner acknowledge bit 14 reads zero
// R18: partner pause 11:10 captured, resets 00
// R19: partner fault, abilities captured, selector 00001
// R20: host reaches registers by index only
// R21: latched bits hold until status read
`ifndef PHYST_DEFINES_SVH
`define PHYST_DEFINES_SVH

// register indexes
`define PHYST_IDX_W 5
`define PHYST_IDX_BASIC_STATUS 5'h01
`define PHYST_IDX_ID_HIGH 5'h02
`define PHYST_IDX_ID_LOW 5'h03
`define PHYST_IDX_ADVERT 5'h04
`define PHYST_IDX_PARTNER 5'h05

// basic status fixed fields
`define PHYST_STAT_ABIL 5'h0F
`define PHYST_STAT_RSVD 5'h00
`define PHYST_STAT_AN_ABLE 1'h1
`define PHYST_STAT_EXT_CAP 1'h1

// identifier fields, values arbitrary
`define PHYST_OUI_HIGH 16'h5A3C
`define PHYST_OUI_LOW 6'h2B
`define PHYST_MODEL 6'h11
`define PHYST_REVISION 4'h3

// advertisement layout and reset values
`define PHYST_ADV_WMASK 16'h3DFF
`define PHYST_ADV_RF_RST 1'h0
`define PHYST_ADV_PAUSE_RST 2'h0
`define PHYST_ADV_TX_RST 1'h1
`define PHYST_SELECTOR_8023 5'h01

// pause codes
`define PHYST_PAUSE_NONE 2'h0
`define PHYST_PAUSE_SYM 2'h1
`define PHYST_PAUSE_ASYM 2'h2
`define PHYST_PAUSE_BOTH 2'h3

// latched status slots
`define PHYST_NLATCH 3
`define PHYST_LATCH_LOW_MASK 3'h2

`endif

/* design/physt_pkg.sv */
/*
 types for the phy status and auto-negotiation register set.
 assumes physt_defines.svh gives the widths used here.
*/
`include "physt_defines.svh"

package physt_pkg;

	typedef struct packed {
		logic autoneg_done;
		logic remote_fault;
		logic link_up;
		logic jabber;
	} physt_line_t;

	typedef struct packed {
		logic next_page;
		logic ack;
		logic remote_fault;
		logic rsvd12;
		logic [1:0] pause;
		logic t4;
		logic tx_fd;
		logic tx;
		logic t10_fd;
		logic t10;
		logic [4:0] selector;
	} physt_word_t;

	typedef struct packed {
		logic [`PHYST_IDX_W-1:0] index;
		logic rd;
		logic wr;
		logic [15:0] wdata;
	} physt_req_t;

	typedef enum logic [0:0] {
		PHYST_AN_IDLE,
		PHYST_AN_DONE
	} physt_an_state_t;

endpackage : physt_pkg

/* design/physt_latch.sv */
/*
 one latching status bit: latching high or latching low by parameter.
 assumes a read strobe of one cycle for the owning register.
*/
`timescale 1ns/10ps
`default_nettype none

module physt_latch #(
	parameter bit LATCH_LOW = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// condition and read
	input wire logic cond,
	input wire logic rd_clear,
	// latched value
	output logic value
);

	logic value_q;
	logic value_d;
	logic held;

	// hold the event, reload the live condition on read
	assign held = LATCH_LOW ? (value_q & cond) : (value_q | cond); // R21
	assign value_d = rd_clear ? cond : held; // R21
	assign value = value_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			value_q <= 1'b0;
		end else begin
			value_q <= value_d;
		end
	end

endmodule : physt_latch

`default_nettype wire

/* design/physt_pause.sv */
/*
 pause resolution: local and partner pause codes to one mode.
 assumes two-bit codes none, symmetric, asymmetric, both.
*/
`timescale 1ns/10ps
`default_nettype none

`include "physt_defines.svh"

module physt_pause (
	// advertised codes
	input wire logic [1:0] local_pause,
	input wire logic [1:0] partner_pause,
	// resolved mode, never both
	output logic [1:0] mode
);

	logic loc_sym;
	logic loc_asym;
	logic par_sym;
	logic par_asym;

	assign loc_sym = local_pause[0];
	assign loc_asym = local_pause[1];
	assign par_sym = partner_pause[0];
	assign par_asym = partner_pause[1];

	// symmetric first, asymmetric only when symmetric fails
	assign mode = (loc_sym && par_sym) ? `PHYST_PAUSE_SYM : // R13
		(loc_asym && par_asym && !(loc_sym && par_sym)) ?
		`PHYST_PAUSE_ASYM : `PHYST_PAUSE_NONE; // R13

endmodule : physt_pause

`default_nettype wire

/* design/physt_regs.sv */
/*
 management registers at indexes 1 to 5 of the integrated phy:
 basic status, two identifiers, advertisement, partner ability.
 assumes the mac access logic presents an index with one-cycle
 read and write strobes, and the line logic gives live conditions.
 soft reset returns every register to its reset value, strap-set abilities included.
 unlisted indexes read zero and ignore writes.
*/
`timescale 1ns/10ps
`default_nettype none

`include "physt_defines.svh"

module physt_regs (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic SOFT_RESET,
	// speed select strap
	input wire logic SPEED_SEL,
	// indexed access from the mac
	input wire physt_pkg::physt_req_t MGMT_REQ,
	output logic [15:0] MGMT_RDATA,
	output logic MGMT_RVALID,
	// line conditions
	input wire physt_pkg::physt_line_t LINE,
	// received partner code word
	input wire physt_pkg::physt_word_t LP_WORD,
	input wire logic LP_VALID,
	// advertised word and resolved pause
	output physt_pkg::physt_word_t ADV_WORD,
	output logic [1:0] PAUSE_MODE
);

	////////////////////////////////////////////////////////////////
	// reset and decode

	logic rst_all;
	logic hit_status;
	logic hit_id_high;
	logic hit_id_low;
	logic hit_advert;
	logic hit_partner;
	logic rd_status;
	logic wr_advert;

	assign rst_all = RST | SOFT_RESET;

	// indexed access only, no memory map
	assign hit_status = MGMT_REQ.index == `PHYST_IDX_BASIC_STATUS; // R20
	assign hit_id_high = MGMT_REQ.index == `PHYST_IDX_ID_HIGH; // R20
	assign hit_id_low = MGMT_REQ.index == `PHYST_IDX_ID_LOW; // R20
	assign hit_advert = MGMT_REQ.index == `PHYST_IDX_ADVERT; // R20
	assign hit_partner = MGMT_REQ.index == `PHYST_IDX_PARTNER; // R20

	assign rd_status = MGMT_REQ.rd & hit_status;
	assign wr_advert = MGMT_REQ.wr & hit_advert;

	////////////////////////////////////////////////////////////////
	// latched status bits

	logic [`PHYST_NLATCH-1:0] latch_cond;
	logic [`PHYST_NLATCH-1:0] latch_val;
	localparam logic [`PHYST_NLATCH-1:0] LATCH_LOW = `PHYST_LATCH_LOW_MASK;

	logic cond_jabber;
	logic cond_link;
	logic cond_rfault;

	assign cond_jabber = LINE.jabber;
	assign cond_link = LINE.link_up;
	assign cond_rfault = LINE.remote_fault;

	// slot 0 jabber, slot 1 link, slot 2 remote fault
	assign latch_cond = {cond_rfault, cond_link, cond_jabber};

	generate
		for (genvar i = 0; i < `PHYST_NLATCH; i++) begin : g_latch
			physt_latch #(
				.LATCH_LOW(LATCH_LOW[i])
			) u_latch (
				.clk(CLOCK),
				.rst(rst_all),
				.cond(latch_cond[i]),
				.rd_clear(rd_status),
				.value(latch_val[i])
			);
		end
	endgenerate

	logic stat_jabber;
	logic stat_link;
	logic stat_rfault;

	assign stat_jabber = latch_val[0]; // R5
	assign stat_link = latch_val[1]; // R4
	assign stat_rfault = latch_val[2]; // R3

	////////////////////////////////////////////////////////////////
	// negotiation state

	physt_pkg::physt_an_state_t an_q;
	physt_pkg::physt_an_state_t an_d;
	logic an_done_d;
	logic an_done_q;
	logic an_rise;

	assign an_rise = (an_q == physt_pkg::PHYST_AN_IDLE) & LINE.autoneg_done;
	assign an_done_d = LINE.autoneg_done; // R2

	always_comb begin
		an_d = an_q;
		unique case (an_q)
			physt_pkg::PHYST_AN_IDLE: begin
				if (LINE.autoneg_done) begin
					an_d = physt_pkg::PHYST_AN_DONE;
				end
			end
			physt_pkg::PHYST_AN_DONE: begin
				if (!LINE.autoneg_done) begin
					an_d = physt_pkg::PHYST_AN_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			an_q <= physt_pkg::PHYST_AN_IDLE;
			an_done_q <= 1'b0;
		end else begin
			an_q <= an_d;
			an_done_q <= an_done_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// basic status word

	logic [15:0] status_word;

	assign status_word = {
		`PHYST_STAT_ABIL, // R1
		`PHYST_STAT_RSVD, // R7
		an_done_q, // R2
		stat_rfault, // R3
		`PHYST_STAT_AN_ABLE, // R6
		stat_link, // R4
		stat_jabber, // R5
		`PHYST_STAT_EXT_CAP // R7
	};

	////////////////////////////////////////////////////////////////
	// identifier words

	logic [15:0] id_high_word;
	logic [15:0] id_low_word;

	assign id_high_word = `PHYST_OUI_HIGH; // R8
	assign id_low_word = {
		`PHYST_OUI_LOW, // R9
		`PHYST_MODEL, // R10
		`PHYST_REVISION // R10
	};

	////////////////////////////////////////////////////////////////
	// advertisement register

	physt_pkg::physt_word_t adv_q;
	physt_pkg::physt_word_t adv_d;
	physt_pkg::physt_word_t adv_rst;
	physt_pkg::physt_word_t adv_wr;
	logic [15:0] adv_wdata;

	// strap picks the reset abilities
	always_comb begin
		adv_rst = '0;
		adv_rst.remote_fault = `PHYST_ADV_RF_RST; // R11
		adv_rst.pause = `PHYST_ADV_PAUSE_RST; // R12
		adv_rst.tx_fd = SPEED_SEL; // R14
		adv_rst.tx = `PHYST_ADV_TX_RST; // R14
		adv_rst.t10_fd = SPEED_SEL; // R14
		adv_rst.t10 = SPEED_SEL; // R14
		adv_rst.selector = `PHYST_SELECTOR_8023; // R15
	end

	// read-only bits 15, 14 and 9 stay zero
	assign adv_wdata = MGMT_REQ.wdata & `PHYST_ADV_WMASK; // R11 R12 R14 R15
	assign adv_wr = physt_pkg::physt_word_t'(adv_wdata);
	assign adv_d = wr_advert ? adv_wr : adv_q;

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			adv_q <= adv_rst; // R14
		end else begin
			adv_q <= adv_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// link partner ability

	physt_pkg::physt_word_t lp_q;
	physt_pkg::physt_word_t lp_d;
	physt_pkg::physt_word_t lp_rst;
	physt_pkg::physt_word_t lp_cap;

	always_comb begin
		lp_rst = '0;
		lp_rst.selector = `PHYST_SELECTOR_8023; // R19
	end

	// next page, acknowledge and reserved never captured
	always_comb begin
		lp_cap = LP_WORD;
		lp_cap.next_page = 1'b0; // R16
		lp_cap.ack = 1'b0; // R17
		lp_cap.rsvd12 = 1'b0;
	end

	assign lp_d = LP_VALID ? lp_cap : lp_q; // R18 R19

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			lp_q <= lp_rst; // R18 R19
		end else begin
			lp_q <= lp_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// pause resolution

	logic [1:0] pause_res;
	logic [1:0] pause_d;
	logic [1:0] pause_q;
	logic [1:0] pause_hold;

	physt_pause u_pause (
		.local_pause(adv_q.pause),
		.partner_pause(lp_q.pause),
		.mode(pause_res)
	);

	// settle once on completion, drop when negotiation is lost
	assign pause_hold = LINE.autoneg_done ? pause_q : `PHYST_PAUSE_NONE;
	assign pause_d = an_rise ? pause_res : pause_hold; // R13

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			pause_q <= `PHYST_PAUSE_NONE;
		end else begin
			pause_q <= pause_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// read path

	logic [15:0] adv_rd_word;
	logic [15:0] lp_rd_word;
	logic [15:0] rd_mux;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic rvalid_d;
	logic rvalid_q;

	assign adv_rd_word = 16'(adv_q);
	assign lp_rd_word = 16'(lp_q);

	// unlisted indexes read zero here
	assign rd_mux = hit_status ? status_word :
		hit_id_high ? id_high_word :
		hit_id_low ? id_low_word :
		hit_advert ? adv_rd_word :
		hit_partner ? lp_rd_word : 16'h0000;

	// read data stands until the next read
	assign rdata_d = MGMT_REQ.rd ? rd_mux : rdata_q;
	assign rvalid_d = MGMT_REQ.rd;

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign MGMT_RDATA = rdata_q;
	assign MGMT_RVALID = rvalid_q;
	assign ADV_WORD = adv_q;
	assign PAUSE_MODE = pause_q;

endmodule : physt_regs

`default_nettype wire

/* bench/physt_chk.sv */
/*
 assertions on the ports of physt_regs.
 assumes a bind onto every physt_regs instance.
*/
`timescale 1ns/10ps
`default_nettype none

module physt_chk (
	// clock and resets
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic SOFT_RESET,
	// access and line
	input wire physt_pkg::physt_req_t MGMT_REQ,
	input wire logic [15:0] MGMT_RDATA,
	input wire logic MGMT_RVALID,
	input wire physt_pkg::physt_line_t LINE,
	// outputs
	input wire physt_pkg::physt_word_t ADV_WORD,
	input wire logic [1:0] PAUSE_MODE
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST || SOFT_RESET);
	wire logic rd = MGMT_REQ.rd;
	wire logic st = rd && MGMT_REQ.index == 5'h01;
	wire logic wa = MGMT_REQ.wr && MGMT_REQ.index == 5'h04;
	wire logic lpr = rd && MGMT_REQ.index == 5'h05;
	//////////////////////////////////////////////////////////////////////
	a_read_answer: assert property (MGMT_RVALID == $past(rd))
		else $error("rvalid wrong");
	a_status_fixed: assert property (st |=>
		(MGMT_RDATA & 16'hFFC9) == 16'h7809) else $error("fixed bits");
	a_jabber_hold: assert property (LINE.jabber ##1 st |=>
		MGMT_RDATA[1]) else $error("jabber lost");
	a_fault_hold: assert property (LINE.remote_fault ##1 st |=>
		MGMT_RDATA[4]) else $error("fault lost");
	a_link_low: assert property (!LINE.link_up ##1 st |=>
		!MGMT_RDATA[2]) else $error("link drop lost");
	a_an_bit: assert property (LINE.autoneg_done ##1 st |=>
		MGMT_RDATA[5]) else $error("done bit");
	a_pause_single: assert property (PAUSE_MODE != 2'h3)
		else $error("pause both");
	a_pause_idle: assert property (!LINE.autoneg_done |=>
		PAUSE_MODE == 2'h0) else $error("pause kept");
	a_adv_write: assert property (wa |=>
		ADV_WORD == ($past(MGMT_REQ.wdata) & 16'h3DFF))
		else $error("advert write");
	a_partner_fixed: assert property (lpr |=>
		MGMT_RDATA[15:14] == 2'h0) else $error("partner fixed bits");
endmodule : physt_chk

bind physt_regs physt_chk physt_chk_i (.CLOCK(CLOCK), .RST(RST),
	.SOFT_RESET(SOFT_RESET), .MGMT_REQ(MGMT_REQ), .MGMT_RDATA(MGMT_RDATA),
	.MGMT_RVALID(MGMT_RVALID), .LINE(LINE), .ADV_WORD(ADV_WORD),
	.PAUSE_MODE(PAUSE_MODE));

`default_nettype wire

/* bench/physt_host.sv */
/*
 host side: indexed requests as the mac access logic presents them.
 assumes put is called just after a rising edge, once a cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module physt_host (
	// request to the registers
	output var physt_pkg::physt_req_t req
);
	initial req = '0;
	task automatic put(input logic r, input logic w, input logic [4:0] i,
		input logic [15:0] d);
		if (r || w) begin
			req <= '{index: i, rd: r, wr: w, wdata: d};
		end else begin
			req <= '{index: ~req.index, rd: 1'h0, wr: 1'h0,
				wdata: ~req.wdata};
		end
	endtask : put
endmodule : physt_host

`default_nettype wire

/* bench/tb.sv */
/*
 random traffic on physt_regs, compared with a cycle model.
 assumes physt_host drives the request port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "physt_defines.svh"

module tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic soft_reset = 1'b0;
	logic speed_sel = 1'b0;
	logic lp_valid = 1'b0;
	logic [15:0] rdata;
	logic rvalid;
	logic [1:0] pause_mode;
	logic [31:0] seed = 32'hDC876670;
	logic [31:0] r;
	physt_pkg::physt_req_t req;
	physt_pkg::physt_line_t line = '0;
	physt_pkg::physt_word_t lp_word = '0;
	physt_pkg::physt_word_t adv_word;
	int err_total = 0;
	int total_checks = 0;
	int adv, lp, rf, jb, lk, an, pm, anst, rv, rdat, st;
	bit clr;
	always #5 clock = ~clock;
	//////////////////////////////////////////////////////////////////////
	physt_host physt_host_i (.req(req));
	physt_regs physt_regs_i (.CLOCK(clock), .RST(rst),
		.SOFT_RESET(soft_reset), .SPEED_SEL(speed_sel), .MGMT_REQ(req),
		.MGMT_RDATA(rdata), .MGMT_RVALID(rvalid), .LINE(line),
		.LP_WORD(lp_word), .LP_VALID(lp_valid), .ADV_WORD(adv_word),
		.PAUSE_MODE(pause_mode));
	//////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string nm, input logic [15:0] s,
		input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic close_out();
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	// model of one clock edge
	task automatic step();
		if (rst || soft_reset) begin
			adv = 16'h0081 | (speed_sel ? 16'h0160 : 16'h0000);
			lp = 16'h0001;
			{rf, jb, lk, an, pm, anst, rv} = '0;
		end else begin
			st = 16'h7809 | an << 5 | rf << 4 | lk << 2 | jb << 1;
			rv = req.rd;
			clr = req.rd && req.index == 5'h01;
			if (req.rd) begin
				case (req.index)
				5'h01: rdat = st;
				5'h02: rdat = `PHYST_OUI_HIGH;
				5'h03: rdat = {`PHYST_OUI_LOW, `PHYST_MODEL, `PHYST_REVISION};
				5'h04: rdat = adv;
				5'h05: rdat = lp;
				default: rdat = 0;
				endcase
			end
			rf = clr ? line.remote_fault : rf | line.remote_fault;
			jb = clr ? line.jabber : jb | line.jabber;
			lk = clr ? line.link_up : lk & line.link_up;
			an = line.autoneg_done;
			if (!line.autoneg_done) begin
				pm = 0;
				anst = 0;
			end else if (!anst) begin
				pm = (adv & lp & 16'h0400) ? 1 : (adv & lp & 16'h0800) ? 2 : 0;
				anst = 1;
			end
			if (req.wr && req.index == 5'h04) adv = req.wdata & 16'h3DFF;
			if (lp_valid) lp = lp_word & 16'h2FFF;
		end
	endtask : step
	//////////////////////////////////////////////////////////////////////
	initial begin
		for (int c = 0; c < 3000; c++) begin
			@(posedge clock);
			step();
			#1;
			chk("rvalid", 16'(rvalid), 16'(rv));
			if (rv) chk("rdata", rdata, 16'(rdat));
			chk("advert", adv_word, 16'(adv));
			chk("pause", 16'(pause_mode), 16'(pm));
			rst = c < 7;
			soft_reset = c >= 1500 && c < 1502;
			speed_sel = c > 1000;
			r = xs();
			if (r[4:0] == 0) line.autoneg_done = ~line.autoneg_done;
			line.remote_fault = r[9:5] == 0;
			line.jabber = r[14:10] == 0;
			line.link_up = r[17:15] != 0;
			lp_valid = r[18] & r[19];
			lp_word = 16'(xs());
			if (rst || soft_reset) begin
				physt_host_i.put(0, 0, 5'h00, 16'h0000);
			end else begin
				physt_host_i.put(r[20], r[21] & r[22], 5'(r[25:23]), 16'(xs()));
			end
		end
		close_out();
	end
endmodule : tb

`default_nettype wire
